// file: bench/decoder_checker_assertions.sv
// Purpose : port-level checks of the settings write decoder
// Assumes : single clock, rst_i asynchronous and active high
// Notes   : applied values may only move at the first edge after a reset
`timescale 1ns/10ps
`default_nettype none
module decoder_checker (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] product_id_o,
  input  wire logic [7:0]  power_attr_o,
  input  wire logic [8:0]  current_ma_o,
  input  wire logic [2:0]  pin_out_o,
  input  wire logic [2:0]  pin_oe_o,
  input  wire logic        rx_activity_led_en_o,
  input  wire logic        suspend_indicator_en_o,
  input  wire logic [1:0]  clock_out_en_o,
  input  wire logic        analog_input_one_en_o,
  input  wire logic        tx_activity_led_en_o,
  input  wire logic        interrupt_detect_en_o,
  input  wire logic        analog_input_two_en_o,
  input  wire logic        analog_output_one_en_o
);
  // ---
  // power-up values
  // ---
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // two edges of grace: the load lands one edge after release
  AST_ENUM_HELD: assert property (!$past(rst_i) && !$past(rst_i, 2) |->
    $stable({product_id_o, power_attr_o, current_ma_o}))
    else $error("enumeration values moved without a reset");
  AST_CURRENT_EVEN: assert property (current_ma_o[0] == 1'b0)
    else $error("requested current is not twice a byte");
  AST_PINS_HELD: assert property (!$past(rst_i) && !$past(rst_i, 2) |->
    $stable({pin_out_o, pin_oe_o}))
    else $error("pin drive moved without a reset");
  AST_ALT_HELD: assert property (!$past(rst_i) && !$past(rst_i, 2) |->
    $stable({rx_activity_led_en_o, suspend_indicator_en_o, clock_out_en_o,
             analog_input_one_en_o, tx_activity_led_en_o, interrupt_detect_en_o,
             analog_input_two_en_o, analog_output_one_en_o}))
    else $error("function enables moved without a reset");
  AST_UNDRIVEN_LOW: assert property ((pin_out_o & ~pin_oe_o) == 3'h0)
    else $error("undriven pin shows a high level");
  AST_PIN0_EXCL: assert property (
    $onehot0({pin_oe_o[0], rx_activity_led_en_o, suspend_indicator_en_o}))
    else $error("pin zero has two functions");
  AST_PIN1_EXCL: assert property ($onehot0({pin_oe_o[1], clock_out_en_o[0],
    analog_input_one_en_o, tx_activity_led_en_o, interrupt_detect_en_o}))
    else $error("pin one has two functions");
  AST_PIN2_EXCL: assert property ($onehot0({pin_oe_o[2], clock_out_en_o[1],
    analog_input_two_en_o, analog_output_one_en_o}))
    else $error("pin two has two functions");
endmodule : decoder_checker

bind flash_settings_write_decoder decoder_checker u_chk (
  .clk_i, .rst_i, .product_id_o, .power_attr_o, .current_ma_o, .pin_out_o, .pin_oe_o,
  .rx_activity_led_en_o, .suspend_indicator_en_o, .clock_out_en_o, .analog_input_one_en_o,
  .tx_activity_led_en_o, .interrupt_detect_en_o, .analog_input_two_en_o,
  .analog_output_one_en_o
);
`default_nettype wire

// file: bench/report_host.sv
// Purpose : host model that loads command reports over the register port
// Assumes : one strobe per transfer, the decoder never stalls
// Notes   : report bytes 2..63 come from rep, filled by the caller
`timescale 1ns/10ps
`default_nettype none
module report_host (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [6:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            we_o,
  output logic            re_o
);
  logic [7:0] rep [64];

  initial begin
    addr_o  = 7'h00;
    wdata_o = 8'h00;
    we_o    = 1'b0;
    re_o    = 1'b0;
  end

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    we_o    <= 1'b1;
    @(posedge clk_i);
    we_o    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    re_o   <= 1'b1;
    @(posedge clk_i);
    re_o   <= 1'b0;
    #1 d = rdata_i;
  endtask : rd

  // go is written last so the decoder never sees a half-loaded report
  task automatic send(input logic [7:0] cmd, input logic [7:0] sub, output logic [7:0] st);
    rep[0] = cmd;
    rep[1] = sub;
    for (int i = 0; i < 64; i++) wr(7'(i), rep[i]);
    wr(7'h40, 8'h01);
    st = 8'h01;
    for (int n = 0; n < 40 && st[0]; n++) rd(7'h41, st);
  endtask : send
endmodule : report_host
`default_nettype wire

// file: bench/tb.sv
// Purpose : self-checking bench of the settings write decoder
// Assumes : settings reach the outputs only through a reset
// Notes   : pin pads mix design drive with an outside level
`timescale 1ns/10ps
`default_nettype none
module tb;
  import flash_settings_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic [6:0]  addr;
  logic [7:0]  wdata;
  logic        we;
  logic        re;
  logic [7:0]  rdata;
  logic [15:0] pid;
  logic [7:0]  pwr;
  logic [8:0]  cur;
  logic [2:0]  ext;
  logic [2:0]  pout;
  logic [2:0]  poe;
  logic [8:0]  alt;
  logic [7:0]  st;
  logic [23:0] cfg [5];
  logic [14:0] expo [5];
  int          mismatches;
  int          compares;

  report_host host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
                    .we_o(we), .re_o(re));

  flash_settings_write_decoder uut (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re),
    .rdata_o(rdata), .product_id_o(pid), .power_attr_o(pwr), .current_ma_o(cur),
    .pin_in_i((poe & pout) | (~poe & ext)), .pin_out_o(pout), .pin_oe_o(poe),
    .rx_activity_led_en_o(alt[8]), .suspend_indicator_en_o(alt[7]),
    .clock_out_en_o(alt[6:5]), .analog_input_one_en_o(alt[4]),
    .tx_activity_led_en_o(alt[3]), .interrupt_detect_en_o(alt[2]),
    .analog_input_two_en_o(alt[1]), .analog_output_one_en_o(alt[0]));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ---
  // helpers
  // ---
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rdchk(input logic [6:0] a, input logic [7:0] e, input string nm);
    logic [7:0] v;
    host.rd(a, v);
    chk(nm, {8'h00, e}, {8'h00, v});
  endtask : rdchk

  task automatic go(input logic [7:0] cmd, input logic [7:0] sub, input logic [7:0] e);
    host.send(cmd, sub, st);
    if (st[0] !== 1'b0) begin
      mismatches++;
      results();
    end
    chk("status", {8'h00, e}, {8'h00, st});
  endtask : go

  task automatic reboot();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : reboot

  task automatic results();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    results();
  end

  // ---
  // main sequence
  // ---
  initial begin
    rst_i      = 1'b1;
    ext        = 3'b101;
    mismatches = 0;
    compares   = 0;
    // {pin zero, pin one, pin two} bytes and {oe, out, enables} expected
    cfg[0] = 24'h1003f8;
    expo[0] = 15'h1208;
    cfg[1] = 24'h010101;
    expo[1] = 15'h0160;
    cfg[2] = 24'h1202fa;
    expo[2] = 15'h0092;
    cfg[3] = 24'h070403;
    expo[3] = 15'h0005;
    cfg[4] = 24'hf00004;
    expo[4] = 15'h3200;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    // erased image: gpio inputs everywhere
    chk("pid", 16'h0808, pid);
    chk("power", 16'h0008, {8'h00, pwr});
    chk("current", 16'h0010, {7'h00, cur});
    chk("pins", 16'h0000, {1'b0, poe, pout, alt});
    repeat (3) @(posedge clk_i);
    rdchk(7'h49, 8'h05, "pin inputs");
    for (int k = 0; k < 5; k++) begin
      for (int i = 2; i < 64; i++) host.rep[i] = 8'hff;
      {host.rep[2], host.rep[3], host.rep[4]} = cfg[k];
      go(8'hb1, 8'h01, 8'h02);
      reboot();
      chk("pin setup", {1'b0, expo[k]}, {1'b0, poe, pout, alt});
    end
    for (int i = 2; i < 64; i++) host.rep[i] = 8'(i) ^ 8'h5a;
    host.rep[8]  = 8'h34;
    host.rep[9]  = 8'h12;
    host.rep[10] = 8'ha0;
    host.rep[11] = 8'h32;
    go(8'hb1, 8'h00, 8'h02);
    chk("pid before reset", 16'h0808, pid);
    rdchk(7'h42, 8'h34, "pid lo");
    rdchk(7'h43, 8'h12, "pid hi");
    rdchk(7'h46, 8'hf0, "pin zero kept");
    rdchk(7'h48, 8'h04, "pin two kept");
    reboot();
    chk("pid", 16'h1234, pid);
    chk("power", 16'h00a0, {8'h00, pwr});
    chk("current", 16'h0064, {7'h00, cur});
    chk("pins kept", {1'b0, expo[4]}, {1'b0, poe, pout, alt});
    rdchk(7'h44, 8'ha0, "power stored");
    rdchk(7'h45, 8'h32, "current stored");
    rdchk(7'h4a, 8'h31, "pin state");
    @(posedge clk_i);
    ext <= 3'b010;
    repeat (3) @(posedge clk_i);
    rdchk(7'h49, 8'h01, "driven pin inputs");
    host.rep[8] = 8'h77;
    go(8'hb1, 8'h05, 8'h06);
    go(8'hb0, 8'h00, 8'h06);
    rdchk(7'h42, 8'h34, "pid lo after refusal");
    results();
  end
endmodule : tb
`default_nettype wire

// file: core/flash_settings_pkg.sv
//------------------------------------------------------------------------------
// Function
// R1: byte 0 = 0xb1 with byte 1 = 0x01 selects the pin power-up settings write.
// R2: byte 0 = 0xb1 with byte 1 = 0x00 selects the chip settings write.
// R3: in a chip settings write, byte 8 is the product id low byte, byte 9 the high byte.
// R4: byte 10 is stored and later reported unchanged as the power attributes field.
// R5: byte 11 is stored and the requested current in mA is twice that value.
// R6: bytes 12 to 19 are the stored eight-byte password; bytes 20 to 63 are ignored.
// R7: in a pin settings write, bytes 2, 3, 4 hold pins zero, one, two; bits 7-5 ignored.
// R8: a pin set as a general-purpose output drives its stored bit 4 after reset.
// R9: stored bit 3 makes a pin an input when 1, an output when 0, only in gpio function.
// R10: pin zero codes: 000 gpio, 001 rx activity led, 010 suspend indicator, rest ignored.
// R11: pin one codes: 000 gpio, 001 clock out, 010 analog in one, 011 tx led, 100 irq.
// R12: pin two codes: 000 gpio, 001 clock out, 010 analog in two, 011 analog out one.
//------------------------------------------------------------------------------
// Purpose : shared constants of the flash settings write decoder
// Assumes : 8-bit register port, 64-byte command reports
// Notes   : nonvolatile image layout is fixed here
//------------------------------------------------------------------------------
package flash_settings_pkg;

  // ----------------------------------------------------------------------------
  // command report layout
  // ----------------------------------------------------------------------------
  localparam int        REPORT_BYTES  = 64;
  localparam logic [7:0] CMD_NV_WRITE = 8'hb1;
  localparam logic [7:0] SUB_CHIP     = 8'h00;
  localparam logic [7:0] SUB_PIN      = 8'h01;
  localparam logic [5:0] IDX_CMD      = 6'h00;
  localparam logic [5:0] IDX_SUB      = 6'h01;
  localparam logic [5:0] IDX_CHIP_LO  = 6'h08;
  localparam logic [5:0] IDX_CHIP_HI  = 6'h13;
  localparam logic [5:0] IDX_PIN_LO   = 6'h02;
  localparam logic [5:0] IDX_PIN_HI   = 6'h04;

  // ----------------------------------------------------------------------------
  // pin settings byte fields and function codes
  // ----------------------------------------------------------------------------
  localparam int         BIT_LEVEL  = 4;
  localparam int         BIT_DIR_IN = 3;
  localparam logic [2:0] FN_GPIO    = 3'h0;
  localparam logic [2:0] FN_ALT1    = 3'h1;
  localparam logic [2:0] FN_ALT2    = 3'h2;
  localparam logic [2:0] FN_ALT3    = 3'h3;
  localparam logic [2:0] FN_ALT4    = 3'h4;

  // ----------------------------------------------------------------------------
  // nonvolatile image layout and erased-state defaults
  // ----------------------------------------------------------------------------
  localparam int         NV_DEPTH  = 16;
  localparam logic [3:0] NV_PID_LO = 4'h0;
  localparam logic [3:0] NV_PID_HI = 4'h1;
  localparam logic [3:0] NV_PWR    = 4'h2;
  localparam logic [3:0] NV_CUR    = 4'h3;
  localparam logic [3:0] NV_PW_LO  = 4'h4;
  localparam logic [3:0] NV_PW_HI  = 4'hb;
  localparam logic [3:0] NV_PIN0   = 4'hc;
  localparam logic [7:0] NV_ERASED = 8'h08;

  // ----------------------------------------------------------------------------
  // register port offsets
  // ----------------------------------------------------------------------------
  localparam logic [6:0] OFS_REPORT_TOP = 7'h3f;
  localparam logic [6:0] OFS_CTRL       = 7'h40;
  localparam logic [6:0] OFS_STATUS     = 7'h41;
  localparam logic [6:0] OFS_PID_LO     = 7'h42;
  localparam logic [6:0] OFS_PID_HI     = 7'h43;
  localparam logic [6:0] OFS_PWR        = 7'h44;
  localparam logic [6:0] OFS_CUR        = 7'h45;
  localparam logic [6:0] OFS_PIN0       = 7'h46;
  localparam logic [6:0] OFS_PIN_IN     = 7'h49;
  localparam logic [6:0] OFS_PIN_STATE  = 7'h4a;
  localparam int         CTRL_GO        = 0;
  localparam int         ST_BUSY        = 0;
  localparam int         ST_DONE        = 1;
  localparam int         ST_BAD_CMD     = 2;

endpackage : flash_settings_pkg

// file: core/flash_settings_write_decoder.sv
//------------------------------------------------------------------------------
// Purpose : decode nonvolatile settings write reports and apply settings at reset
// Assumes : software loads a 64-byte report, then writes the go bit
// Notes   : stored settings take effect only at the next reset, as power-up values
//------------------------------------------------------------------------------
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module flash_settings_write_decoder
  import flash_settings_pkg::*;
#(
  parameter int PINS = 3
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // register port
  input  wire logic [6:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  output logic      [7:0]  rdata_o,
  // enumeration values
  output logic      [15:0] product_id_o,
  output logic      [7:0]  power_attr_o,
  output logic      [8:0]  current_ma_o,
  // general-purpose pins
  input  wire logic [2:0]  pin_in_i,
  output logic      [2:0]  pin_out_o,
  output logic      [2:0]  pin_oe_o,
  // alternate function enables
  output logic             rx_activity_led_en_o,
  output logic             suspend_indicator_en_o,
  output logic      [1:0]  clock_out_en_o,
  output logic             analog_input_one_en_o,
  output logic             tx_activity_led_en_o,
  output logic             interrupt_detect_en_o,
  output logic             analog_input_two_en_o,
  output logic             analog_output_one_en_o
);

  // only three pins have code tables, so any other count is refused at elaboration
  if (PINS != 3) begin : g_bad_pins
    $error("flash_settings_write_decoder: exactly three pins are decoded");
  end

  // ----------------------------------------------------------------------------
  // types and state
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CHIP,
    ST_PIN
  } walk_state_t;

  walk_state_t state;
  walk_state_t next_state;
  logic [5:0]  src;
  logic [5:0]  next_src;
  logic        done;
  logic        next_done;
  logic        bad_cmd;
  logic        next_bad_cmd;
  logic        nv_we;
  logic        next_nv_we;
  logic [3:0]  nv_addr;
  logic [3:0]  next_nv_addr;
  logic [7:0]  nv_data;
  logic [7:0]  next_nv_data;

  logic [7:0]  report [REPORT_BYTES];
  logic [7:0]  rdata;
  logic [7:0]  next_rdata;
  logic [2:0]  pin_sync1;
  logic [2:0]  pin_sync2;

  logic        apply;
  logic        next_apply;
  logic [15:0] pid;
  logic [15:0] next_pid;
  logic [7:0]  pwr;
  logic [7:0]  next_pwr;
  logic [8:0]  cur_ma;
  logic [8:0]  next_cur_ma;
  logic [2:0]  pin_out;
  logic [2:0]  next_pin_out;
  logic [2:0]  pin_oe;
  logic [2:0]  next_pin_oe;
  logic [4:1]  alt      [3];
  logic [4:1]  next_alt [3];

  logic [8*NV_DEPTH-1:0] image;
  logic [2:0]            dec_drive;
  logic [2:0]            dec_level;
  logic [4:1]            dec_alt [3];

  logic       busy;
  logic       go;
  logic       cmd_ok;
  logic       ctrl_wr;
  logic       report_wr;
  logic [7:0] status;
  logic [7:0] pin_state;

  assign busy      = (state != ST_IDLE);
  assign ctrl_wr   = we_i && (addr_i == OFS_CTRL);
  assign report_wr = we_i && !busy && (addr_i <= OFS_REPORT_TOP);
  // go is refused while busy, so done and bad_cmd never see a set and a clear at once
  assign go        = ctrl_wr && wdata_i[CTRL_GO] && !busy;
  assign cmd_ok    = (report[IDX_CMD] == CMD_NV_WRITE);
  assign status    = {5'h00, bad_cmd, done, busy};
  assign pin_state = {1'b0, pin_oe, 1'b0, pin_out};

  // ----------------------------------------------------------------------------
  // report buffer; loads are ignored while a walk reads it
  // ----------------------------------------------------------------------------
  // no reset: a report means nothing until software has loaded it
  always_ff @(posedge clk_i) begin
    if (report_wr) begin
      report[addr_i[5:0]] <= wdata_i;
    end
  end

  // ----------------------------------------------------------------------------
  // command walk: copies one report byte into the image per cycle
  // ----------------------------------------------------------------------------
  always_comb begin
    next_state   = state;
    next_src     = src;
    next_done    = done;
    next_bad_cmd = bad_cmd;
    next_nv_we   = 1'b0;
    next_nv_addr = nv_addr;
    next_nv_data = nv_data;
    unique case (state)
      ST_IDLE: begin
        if (go) begin
          next_done    = 1'b0;
          next_bad_cmd = 1'b0;
          if (cmd_ok && report[IDX_SUB] == SUB_CHIP) begin         // [R2]
            next_state = ST_CHIP;
            next_src   = IDX_CHIP_LO;                              // [R3]
          end else if (cmd_ok && report[IDX_SUB] == SUB_PIN) begin // [R1]
            next_state = ST_PIN;
            next_src   = IDX_PIN_LO;                               // [R7]
          end else begin
            // unknown command: nothing is written and the walk ends at once
            next_bad_cmd = 1'b1;
            next_done    = 1'b1;
          end
        end
      end
      ST_CHIP: begin
        // bytes 8..19 land at image 0..11: pid, power, current, password
        // nv_we is registered, so each byte lands one edge after it is picked
        next_nv_we   = 1'b1;
        next_nv_addr = 4'(src - IDX_CHIP_LO);                      // [R3] [R4] [R5] [R6]
        next_nv_data = report[src];
        next_src     = 6'(src + 6'h01);
        if (src == IDX_CHIP_HI) begin                              // [R6]
          next_state = ST_IDLE;
          next_done  = 1'b1;
        end
      end
      ST_PIN: begin
        next_nv_we   = 1'b1;
        next_nv_addr = 4'(src - IDX_PIN_LO) + NV_PIN0;             // [R7]
        next_nv_data = report[src];
        next_src     = 6'(src + 6'h01);
        if (src == IDX_PIN_HI) begin
          next_state = ST_IDLE;
          next_done  = 1'b1;
        end
      end
      // the fourth state code is illegal; fall back to idle
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state   <= ST_IDLE;
      src     <= 6'h00;
      done    <= 1'b0;
      bad_cmd <= 1'b0;
      nv_we   <= 1'b0;
      nv_addr <= 4'h0;
      nv_data <= 8'h00;
    end else begin
      state   <= next_state;
      src     <= next_src;
      done    <= next_done;
      bad_cmd <= next_bad_cmd;
      nv_we   <= next_nv_we;
      nv_addr <= next_nv_addr;
      nv_data <= next_nv_data;
    end
  end

  // the image has no reset port: stored settings must outlive rst_i
  nv_image #(
    .DEPTH (NV_DEPTH)
  ) u_nv (
    .clk_i   (clk_i),
    .we_i    (nv_we),
    .addr_i  (nv_addr),
    .data_i  (nv_data),
    .image_o (image)
  );

  // ----------------------------------------------------------------------------
  // pin decode, one per pin
  // ----------------------------------------------------------------------------
  // pin bytes sit above the twelve chip bytes in the image
  generate
    for (genvar p = 0; p < 3; p++) begin : g_pin
      pin_cfg_decode #(
        .PIN (p)
      ) u_dec (
        .cfg_i   (image[8*(int'(NV_PIN0) + p) +: 8]),              // [R7]
        .drive_o (dec_drive[p]),
        .level_o (dec_level[p]),
        .alt_o   (dec_alt[p])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // power-up apply: stored settings are taken once, right after reset
  // ----------------------------------------------------------------------------
  always_comb begin
    next_apply   = 1'b0;
    next_pid     = pid;
    next_pwr     = pwr;
    next_cur_ma  = cur_ma;
    next_pin_out = pin_out;
    next_pin_oe  = pin_oe;
    next_alt     = alt;
    // apply is high for one edge only and stays low until the next rst_i
    if (apply) begin
      next_pid     = {image[8*NV_PID_HI +: 8], image[8*NV_PID_LO +: 8]}; // [R3]
      next_pwr     = image[8*NV_PWR +: 8];                             // [R4]
      next_cur_ma  = {image[8*NV_CUR +: 8], 1'b0};                     // [R5]
      next_pin_out = dec_level & dec_drive;                            // [R8]
      next_pin_oe  = dec_drive;                                        // [R9]
      next_alt[0]  = dec_alt[0];
      next_alt[1]  = dec_alt[1];
      next_alt[2]  = dec_alt[2];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      apply   <= 1'b1;
      pid     <= 16'h0000;
      pwr     <= 8'h00;
      cur_ma  <= 9'h000;
      pin_out <= 3'h0;
      pin_oe  <= 3'h0;
      alt[0]  <= 4'h0;
      alt[1]  <= 4'h0;
      alt[2]  <= 4'h0;
    end else begin
      apply   <= next_apply;
      pid     <= next_pid;
      pwr     <= next_pwr;
      cur_ma  <= next_cur_ma;
      pin_out <= next_pin_out;
      pin_oe  <= next_pin_oe;
      alt     <= next_alt;
    end
  end

  // ----------------------------------------------------------------------------
  // pin input synchroniser
  // ----------------------------------------------------------------------------
  // only pin_sync2 is read beyond this block; pin_sync1 may still be settling
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_sync1 <= 3'h0;
      pin_sync2 <= 3'h0;
    end else begin
      pin_sync1 <= pin_in_i;
      pin_sync2 <= pin_sync1;
    end
  end

  // ----------------------------------------------------------------------------
  // register read; the password never reads back from the image, but its report buffer copy still does
  // ----------------------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    if (re_i) begin
      if (addr_i <= OFS_REPORT_TOP) begin
        next_rdata = report[addr_i[5:0]];
      end else begin
        unique case (addr_i)
          OFS_STATUS:          next_rdata = status;
          OFS_PID_LO:          next_rdata = image[8*NV_PID_LO +: 8];
          OFS_PID_HI:          next_rdata = image[8*NV_PID_HI +: 8];
          OFS_PWR:             next_rdata = image[8*NV_PWR +: 8];
          OFS_CUR:             next_rdata = image[8*NV_CUR +: 8];
          OFS_PIN0:            next_rdata = image[8*NV_PIN0 +: 8];
          OFS_PIN0 + 7'h01:    next_rdata = image[8*(NV_PIN0 + 4'h1) +: 8];
          OFS_PIN0 + 7'h02:    next_rdata = image[8*(NV_PIN0 + 4'h2) +: 8];
          OFS_PIN_IN:          next_rdata = {5'h00, pin_sync2};
          OFS_PIN_STATE:       next_rdata = pin_state;
          default:       next_rdata = 8'h00;
        endcase
      end
    end
  end

  // rdata falls back to zero after one cycle, so a stale read never looks fresh
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------------------
  assign rdata_o                = rdata;
  assign product_id_o           = pid;
  assign power_attr_o           = pwr;
  assign current_ma_o           = cur_ma;
  assign pin_out_o              = pin_out;
  assign pin_oe_o               = pin_oe;
  assign rx_activity_led_en_o   = alt[0][1];   // [R10]
  assign suspend_indicator_en_o = alt[0][2];   // [R10]
  // one clock output enable per pin, pins one and two
  assign clock_out_en_o         = {alt[2][1], alt[1][1]};   // [R11] [R12]
  assign analog_input_one_en_o  = alt[1][2];   // [R11]
  assign tx_activity_led_en_o   = alt[1][3];   // [R11]
  assign interrupt_detect_en_o  = alt[1][4];   // [R11]
  assign analog_input_two_en_o  = alt[2][2];   // [R12]
  assign analog_output_one_en_o = alt[2][3];   // [R12]

endmodule : flash_settings_write_decoder
`default_nettype wire

// file: core/nv_image.sv
//------------------------------------------------------------------------------
// Purpose : nonvolatile settings image, one byte written per cycle
// Assumes : contents survive rst_i, as flash would
// Notes   : whole image is visible at once as a flat vector
//------------------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module nv_image
  import flash_settings_pkg::*;
#(
  parameter int DEPTH = NV_DEPTH
) (
  input  wire logic               clk_i,
  input  wire logic               we_i,
  input  wire logic [3:0]         addr_i,
  input  wire logic [7:0]         data_i,
  output logic      [8*DEPTH-1:0] image_o
);

  // erased flash reads as NV_ERASED; a declaration value keeps always_ff the only writer
  logic [7:0] mem [DEPTH] = '{default: NV_ERASED};

  if (DEPTH < 15 || DEPTH > 16) begin : g_bad_depth
    $error("nv_image: depth must hold the fifteen settings bytes");
  end

  // no reset on purpose: the image must outlive a device reset
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= data_i;
    end
  end

  generate
    for (genvar g = 0; g < DEPTH; g++) begin : g_flat
      assign image_o[8*g +: 8] = mem[g];
    end
  endgenerate

endmodule : nv_image
`default_nettype wire

// file: core/pin_cfg_decode.sv
//------------------------------------------------------------------------------
// Purpose : turn one stored pin settings byte into drive and function enables
// Assumes : PIN selects which code table applies
// Notes   : an ignored code leaves the pin undriven with no function
//------------------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module pin_cfg_decode
  import flash_settings_pkg::*;
#(
  parameter int PIN = 0
) (
  input  wire logic [7:0] cfg_i,
  output logic            drive_o,
  output logic            level_o,
  output logic      [4:1] alt_o
);

  logic [2:0] code;
  logic [2:0] top_code;

  if (PIN < 0 || PIN > 2) begin : g_bad_pin
    $error("pin_cfg_decode: only pins zero to two are decoded");
  end

  assign code     = cfg_i[2:0];                          // [R7]
  assign top_code = (PIN == 0) ? FN_ALT2 : (PIN == 1) ? FN_ALT4 : FN_ALT3; // [R10] [R11] [R12]

  always_comb begin
    alt_o   = '0;
    drive_o = 1'b0;
    level_o = cfg_i[BIT_LEVEL];                          // [R8]
    if (code == FN_GPIO) begin
      drive_o = ~cfg_i[BIT_DIR_IN];                      // [R9]
    end else if (code <= top_code) begin
      alt_o[code] = 1'b1;                                // [R10] [R11] [R12]
    end
  end

endmodule : pin_cfg_decode
`default_nettype wire
